// ### srb_pkg.sv
/*
  Shared constants and types for the serial receiver status/buffer block.
  Assumes a single 20 MHz core clock and a 16x oversampled receive line.
*/
package srb_pkg;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int CLR_PULSE_NS  = 1000;
  localparam int CLR_PULSE_RAW = CLR_PULSE_NS / CLK_PERIOD_NS;
  localparam int CLR_PULSE_INT = (CLR_PULSE_RAW < 1) ? 1 : CLR_PULSE_RAW;
  localparam int CLR_CNT_W     = 5;
  localparam logic [CLR_CNT_W-1:0] CLR_PULSE_CYC = CLR_CNT_W'(CLR_PULSE_INT);

  localparam int OVERSAMPLE = 16;
  localparam int MID_SAMPLE = 8;
  localparam logic [3:0] MID_TICK = 4'(MID_SAMPLE - 1);
  localparam logic [3:0] BIT_TICK = 4'(OVERSAMPLE - 1);
  localparam int DIV_W = 16;

  // ------------------------------------------------------------------
  // bit positions
  // ------------------------------------------------------------------
  localparam int ST_ACT   = 11;
  localparam int ST_DONE  = 7;
  localparam int ST_IE    = 6;
  localparam int ST_TAPE  = 0;
  localparam int BUF_ERR  = 15;
  localparam int BUF_OVR  = 14;
  localparam int BUF_FRM  = 13;
  localparam int BUF_PAR  = 12;
  localparam int DATA_MAX = 8;
  localparam logic [3:0] DATA_MIN_BITS = 4'h5;
  localparam logic [3:0] DATA_MAX_BITS = 4'h8;
  localparam logic       LINE_MARK = 1'b1;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    RX_IDLE   = 3'h0,
    RX_START  = 3'h1,
    RX_DATA   = 3'h2,
    RX_PARITY = 3'h3,
    RX_STOP   = 3'h4
  } srb_rx_state_t;

  typedef struct packed {
    logic [3:0] dataBits;
    logic       parityEn;
    logic       parityOdd;
    logic       errReport;
  } srb_cfg_t;

  typedef struct packed {
    logic        selStatus;
    logic        selBuffer;
    logic        rd;
    logic        wr;
    logic [15:0] wrData;
  } srb_bus_req_t;

  typedef struct packed {
    logic                 rxSync1;
    logic                 rxSync2;
    srb_cfg_t             cfgSync1;
    srb_cfg_t             cfgSync2;
    logic [DIV_W-1:0]     divCnt;
    srb_rx_state_t        rxState;
    logic [3:0]           phase;
    logic [2:0]           bitIdx;
    logic [DATA_MAX-1:0]  shift;
    logic                 parAcc;
    logic                 parErr;
    logic [DATA_MAX-1:0]  holding;
    logic                 ovr;
    logic                 frm;
    logic                 par;
    logic                 act;
    logic                 done;
    logic                 ie;
    logic                 tape;
    logic                 irq;
    logic                 irqArm;
    logic [CLR_CNT_W-1:0] clrCnt;
    logic [15:0]          rdData;
  } srb_state_t;

endpackage

// ### srb_receiver.sv
/*
  Receive half of an asynchronous serial line unit: receiver status word,
  receiver buffer word and the 16x oversampling receiver behind them.
  Assumes bus strobes come from logic on core_clk; rxLine and the
  configuration straps come from pins and are synchronised here.
*/
// Function
// - receiver active sets on eighth sample tick after start edge.
// - active is read-only; cleared by character received and bus initialize.
// - read-only character-received flag at status bit 7 on completion.
// - received flag rising with enable set raises interrupt request.
// - received flag cleared by initialize and by reading the buffer.
// - buffer read starts a one microsecond clear pulse on the flag.
// - tape advance control holds the received flag cleared.
// - interrupt enable is read/write at bit 6, cleared by initialize.
// - tape advance loads from data bit 0 and drives the reader output.
// - tape advance control is write-only and reads back as zero.
// - tape advance clears when active sets and on initialize.
// - eight data bits read-only, held until next character completes.
// - short characters are right-justified into low buffer bits.
// - data presents mark as one and space as zero.
// - overrun flag bit 14 when character completes before previous read.
// - framing flag bit 13 when stop bit is not valid.
// - parity flag bit 12 on mismatch when parity is enabled.
// - bit 15 is the OR of overrun, framing and parity flags.
// - error report switch gates all four error bits onto reads.
// - error flags raise no interrupt; updated every character.
// - bus initialize leaves the buffer data unchanged.
`timescale 1ns/1ps
module srb_receiver #(
  parameter int SAMPLE_DIV = 65
) (
  input  wire logic                 core_clk,
  input  wire logic                 resetn,
  input  wire logic                 busInit,
  input  wire srb_pkg::srb_bus_req_t busReq,
  output logic      [15:0]          busRdData,
  input  wire logic                 irqAck,
  output logic                      irqRequest,
  output logic                      tapeAdvance,
  input  wire logic                 rxLine,
  input  wire srb_pkg::srb_cfg_t    cfgIn
);

  // ------------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------------
  if (SAMPLE_DIV < 1 || SAMPLE_DIV > (1 << srb_pkg::DIV_W)
      || srb_pkg::CLR_PULSE_INT >= (1 << srb_pkg::CLR_CNT_W)) begin : g_chk
    $error("divider or clear pulse length out of range");
  end

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // index of the last data bit for the configured length
  function automatic logic [2:0] lastIdx(input logic [3:0] nBits);
    logic [3:0] n;
    n = nBits;
    if (n < srb_pkg::DATA_MIN_BITS) begin
      n = srb_pkg::DATA_MIN_BITS;
    end
    if (n > srb_pkg::DATA_MAX_BITS) begin
      n = srb_pkg::DATA_MAX_BITS;
    end
    lastIdx = 3'(n - 4'h1);
  endfunction

  srb_pkg::srb_state_t s;
  srb_pkg::srb_state_t next_s;
  logic                tick;
  logic                complete;
  logic                line;
  logic [15:0]         statusWord;
  logic [15:0]         bufferWord;
  srb_pkg::srb_cfg_t   cfg;

  assign line = s.rxSync2;
  assign cfg  = s.cfgSync2;

  // ------------------------------------------------------------------
  // read views
  // ------------------------------------------------------------------
  always_comb begin
    statusWord = 16'h0000;
    statusWord[srb_pkg::ST_ACT]  = s.act;
    statusWord[srb_pkg::ST_DONE] = s.done;
    statusWord[srb_pkg::ST_IE]   = s.ie;
    // tape advance bit stays zero here
    bufferWord = 16'h0000;
    bufferWord[srb_pkg::DATA_MAX-1:0] = s.holding;
    if (cfg.errReport) begin
      bufferWord[srb_pkg::BUF_OVR] = s.ovr;
      bufferWord[srb_pkg::BUF_FRM] = s.frm;
      bufferWord[srb_pkg::BUF_PAR] = s.par;
      bufferWord[srb_pkg::BUF_ERR] = s.ovr | s.frm | s.par;
    end
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    next_s   = s;
    complete = 1'b0;
    tick     = (s.divCnt == srb_pkg::DIV_W'(SAMPLE_DIV - 1));
    next_s.rxSync1  = rxLine;
    next_s.rxSync2  = s.rxSync1;
    next_s.cfgSync1 = cfgIn;
    next_s.cfgSync2 = s.cfgSync1;
    next_s.divCnt   = tick ? '0 : s.divCnt + srb_pkg::DIV_W'(1);
    if (tick) begin
      next_s.phase = s.phase + 4'h1;
    end

    // status write: only enable and tape advance are stored
    if (busReq.wr && busReq.selStatus) begin
      next_s.ie   = busReq.wrData[srb_pkg::ST_IE];
      next_s.tape = busReq.wrData[srb_pkg::ST_TAPE];
    end

    case (s.rxState)
      srb_pkg::RX_IDLE: begin
        next_s.phase = '0;
        if (line != srb_pkg::LINE_MARK) begin
          next_s.rxState = srb_pkg::RX_START;
        end
      end
      srb_pkg::RX_START: begin
        if (tick && s.phase == srb_pkg::MID_TICK) begin
          next_s.phase = '0;
          if (line != srb_pkg::LINE_MARK) begin
            next_s.rxState = srb_pkg::RX_DATA;
            next_s.act     = 1'b1;
            next_s.tape    = 1'b0;
            next_s.bitIdx  = '0;
            next_s.shift   = '0;
            next_s.parAcc  = 1'b0;
            next_s.parErr  = 1'b0;
          end else begin
            // glitch shorter than half a bit
            next_s.rxState = srb_pkg::RX_IDLE;
          end
        end
      end
      srb_pkg::RX_DATA: begin
        if (tick && s.phase == srb_pkg::BIT_TICK) begin
          next_s.shift[s.bitIdx] = line;
          next_s.parAcc = s.parAcc ^ line;
          if (s.bitIdx == lastIdx(cfg.dataBits)) begin
            next_s.rxState = cfg.parityEn ? srb_pkg::RX_PARITY : srb_pkg::RX_STOP;
          end else begin
            next_s.bitIdx = s.bitIdx + 3'h1;
          end
        end
      end
      srb_pkg::RX_PARITY: begin
        if (tick && s.phase == srb_pkg::BIT_TICK) begin
          next_s.parErr  = (s.parAcc ^ line) != cfg.parityOdd;
          next_s.rxState = srb_pkg::RX_STOP;
        end
      end
      srb_pkg::RX_STOP: begin
        if (tick && s.phase == srb_pkg::BIT_TICK) begin
          complete       = 1'b1;
          next_s.rxState = srb_pkg::RX_IDLE;
        end
      end
      default: begin
        next_s.rxState = srb_pkg::RX_IDLE;
      end
    endcase

    // character completion: data, errors, done; errors raise no irq
    if (complete) begin
      next_s.holding = s.shift;
      next_s.ovr     = s.done;
      next_s.frm     = (line != srb_pkg::LINE_MARK);
      next_s.par     = s.parErr & cfg.parityEn;
    end

    // clear pulse on buffer read
    if (busReq.rd && busReq.selBuffer) begin
      next_s.clrCnt = srb_pkg::CLR_PULSE_CYC;
    end else if (s.clrCnt != '0) begin
      next_s.clrCnt = s.clrCnt - srb_pkg::CLR_CNT_W'(1);
    end

    // set of the received flag wins over its clear
    if (complete) begin
      next_s.done = 1'b1;
      next_s.act  = 1'b0;
    end else if (s.clrCnt != '0 || s.tape) begin
      next_s.done = 1'b0;
    end

    // interrupt request on rising done-and-enable
    next_s.irqArm = s.done & s.ie;
    if (s.done && s.ie && !s.irqArm) begin
      next_s.irq = 1'b1;
    end else if (irqAck) begin
      next_s.irq = 1'b0;
    end

    // read data register
    if (busReq.rd) begin
      if (busReq.selStatus) begin
        next_s.rdData = statusWord;
      end else if (busReq.selBuffer) begin
        next_s.rdData = bufferWord;
      end else begin
        next_s.rdData = 16'h0000;
      end
    end

    // bus initialize: holding data is left alone
    if (busInit) begin
      next_s.act     = 1'b0;
      next_s.done    = 1'b0;
      next_s.ie      = 1'b0;
      next_s.tape    = 1'b0;
      next_s.irq     = 1'b0;
      next_s.irqArm  = 1'b0;
      next_s.clrCnt  = '0;
      next_s.rxState = srb_pkg::RX_IDLE;
    end
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s         <= '0;
      s.rxSync1 <= 1'b1;
      s.rxSync2 <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign busRdData   = s.rdData;
  assign irqRequest  = s.irq;
  assign tapeAdvance = s.tape;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  property p_act_mid;
    (s.rxState == srb_pkg::RX_START && tick && s.phase == srb_pkg::MID_TICK
     && !line && !busInit) |=> s.act && !s.tape;
  endproperty
  a_act_mid: assert property (p_act_mid) else $error("active not set mid start");

  property p_act_clr;
    $rose(s.done) |-> !s.act;
  endproperty
  a_act_clr: assert property (p_act_clr) else $error("active not cleared by done");

  property p_irq_set;
    (s.done && s.ie && !s.irqArm && !busInit) |=> s.irq;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("interrupt request missed");

  property p_rd_pulse;
    (busReq.rd && busReq.selBuffer && !busInit) |=> (s.clrCnt == srb_pkg::CLR_PULSE_CYC);
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("clear pulse not started");

  property p_clr_done;
    (s.clrCnt != '0 && !complete) |=> !s.done;
  endproperty
  a_clr_done: assert property (p_clr_done) else $error("done survived clear pulse");

  property p_tape_hold;
    (s.tape && !complete) |=> !s.done;
  endproperty
  a_tape_hold: assert property (p_tape_hold) else $error("done set under tape advance");

  property p_ie_wr;
    (busReq.wr && busReq.selStatus && !busInit) |=> s.ie == $past(busReq.wrData[srb_pkg::ST_IE]);
  endproperty
  a_ie_wr: assert property (p_ie_wr) else $error("enable not loaded");

  property p_status_hide;
    (busReq.rd && busReq.selStatus) |=> busRdData[srb_pkg::ST_TAPE] == 1'b0
      && busRdData[15:12] == 4'h0 && busRdData[5:1] == 5'h00;
  endproperty
  a_status_hide: assert property (p_status_hide) else $error("hidden status bits visible");

  property p_overrun;
    (complete && s.done) |=> s.ovr;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_err_or;
    (busReq.rd && busReq.selBuffer) |=> busRdData[srb_pkg::BUF_ERR] == (|busRdData[14:12]);
  endproperty
  a_err_or: assert property (p_err_or) else $error("summary error bit wrong");

  property p_err_gate;
    (busReq.rd && busReq.selBuffer && !cfg.errReport) |=> busRdData[15:12] == 4'h0;
  endproperty
  a_err_gate: assert property (p_err_gate) else $error("error bits not gated");

  property p_init_keep;
    (busInit && !complete) |=> s.holding == $past(s.holding);
  endproperty
  a_init_keep: assert property (p_init_keep) else $error("initialize touched buffer");

  property p_done_set;
    (complete && !busInit) |=> s.done;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done not set on completion");

  property p_tape_clr;
    $rose(s.act) |-> !s.tape;
  endproperty
  a_tape_clr: assert property (p_tape_clr) else $error("tape not cleared by active");

  property p_frame;
    complete |=> s.frm == ($past(line) != srb_pkg::LINE_MARK);
  endproperty
  a_frame: assert property (p_frame) else $error("framing flag wrong");

  property p_par_off;
    (complete && !cfg.parityEn) |=> !s.par;
  endproperty
  a_par_off: assert property (p_par_off) else $error("parity flag without parity");

  property p_tape_wr;
    (busReq.wr && busReq.selStatus && !busInit && s.rxState != srb_pkg::RX_START)
      |=> tapeAdvance == $past(busReq.wrData[srb_pkg::ST_TAPE]);
  endproperty
  a_tape_wr: assert property (p_tape_wr) else $error("tape advance not loaded");

  property p_hold_data;
    !complete |=> $stable(s.holding);
  endproperty
  a_hold_data: assert property (p_hold_data) else $error("buffer data changed");

  property p_no_err_irq;
    (!s.irq && !(s.done && s.ie && !s.irqArm)) |=> !s.irq;
  endproperty
  a_no_err_irq: assert property (p_no_err_irq) else $error("interrupt without done");

  property p_init_clr;
    busInit |=> !s.act && !s.done && !s.ie && !s.tape && !s.irq;
  endproperty
  a_init_clr: assert property (p_init_clr) else $error("initialize left flags set");

endmodule

// ### srb_terminal.sv
/*
  Model of the serial terminal that drives the receive line.
  Assumes the bench calls send_char just after a core_clk edge.
*/
`timescale 1ns/1ps
module srb_terminal #(
  parameter int SAMPLE_DIV = 2
) (
  input  wire logic core_clk,
  output logic      rxLine
);
  localparam int BIT_CLK = 16 * SAMPLE_DIV;

  // line idles at mark
  initial rxLine = 1'b1;

  task automatic hold_bit(input logic b, input int n);
    rxLine <= b;
    repeat (n) @(posedge core_clk);
  endtask

  // lsb first; even parity unless badPar flips it
  task automatic send_char(input logic [7:0] d, input int nb, input logic withPar,
                           input logic badPar, input logic badStop);
    logic p;
    p = badPar;
    @(posedge core_clk);
    hold_bit(1'b0, BIT_CLK);
    for (int i = 0; i < nb; i++) begin
      hold_bit(d[i], BIT_CLK);
      p = p ^ d[i];
    end
    if (withPar) hold_bit(p, BIT_CLK);
    // short space stop: sampled low, too short to pass for a new start
    if (badStop) hold_bit(1'b0, BIT_CLK / 2 + 4);
    hold_bit(1'b1, 2 * BIT_CLK);
  endtask
endmodule

// ### srb_receiver_bench.sv
/*
  Self-checking bench for the receiver status and buffer words.
  Assumes srb_pkg, srb_receiver and srb_terminal are compiled first.
*/
`timescale 1ns/1ps
module srb_receiver_bench;
  localparam int DIV = 2;

  logic                  core_clk;
  logic                  resetn;
  logic                  busInit;
  srb_pkg::srb_bus_req_t busReq;
  logic [15:0]           busRdData;
  logic                  irqAck;
  logic                  irqRequest;
  logic                  tapeAdvance;
  logic                  rxLine;
  srb_pkg::srb_cfg_t     cfg;
  int                    errorCnt;
  int                    nCompared;

  srb_receiver #(.SAMPLE_DIV(DIV)) i_srb_receiver (
    .core_clk(core_clk), .resetn(resetn), .busInit(busInit), .busReq(busReq),
    .busRdData(busRdData), .irqAck(irqAck), .irqRequest(irqRequest),
    .tapeAdvance(tapeAdvance), .rxLine(rxLine), .cfgIn(cfg));

  srb_terminal #(.SAMPLE_DIV(DIV)) i_srb_terminal (.core_clk(core_clk), .rxLine(rxLine));

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    nCompared++;
    if (got !== exp) begin
      errorCnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus(input logic sS, input logic rd, input logic [15:0] d);
    @(posedge core_clk);
    busReq <= '{sS, !sS, rd, !rd, d};
    @(posedge core_clk);
    busReq <= '0;
    #1;
  endtask

  task automatic rdc(input logic sS, input string what, input logic [15:0] exp);
    bus(sS, 1'b1, 16'h0000);
    chk(what, exp, busRdData);
  endtask

  task automatic flag(input string what, input logic exp, input logic got);
    chk(what, {15'h0000, exp}, {15'h0000, got});
  endtask

  task automatic pulse(input logic ack);
    @(posedge core_clk);
    if (ack) irqAck <= 1'b1;
    else busInit <= 1'b1;
    @(posedge core_clk);
    irqAck <= 1'b0;
    busInit <= 1'b0;
    #1;
  endtask

  task automatic snd(input logic [7:0] d, input int nb, input logic wp, input logic bp,
                     input logic bs);
    i_srb_terminal.send_char(d, nb, wp, bp, bs);
    repeat (4) @(posedge core_clk);
    #1;
  endtask

  task automatic endt(input string name);
    $display("test %s finished", name);
  endtask

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // clock, reset, watchdog
  // ------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    errorCnt++;
    report_and_stop();
  end

  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial begin
    errorCnt = 0;
    nCompared = 0;
    resetn = 1'b0;
    busInit = 1'b0;
    busReq = '0;
    irqAck = 1'b0;
    cfg = '{4'h8, 1'b0, 1'b0, 1'b1};
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    rdc(1'b1, "status after reset", 16'h0000);
    flag("tape after reset", 1'b0, tapeAdvance);
    endt("reset");

    bus(1'b1, 1'b0, 16'hffff);
    rdc(1'b1, "status after write", 16'h0040);
    flag("tape set", 1'b1, tapeAdvance);
    endt("status write");

    fork
      snd(8'ha5, 8, 1'b0, 1'b0, 1'b0);
      begin
        repeat (24) @(posedge core_clk);
        rdc(1'b1, "status mid start", 16'h0840);
        flag("tape after start", 1'b0, tapeAdvance);
      end
    join
    flag("irq raised", 1'b1, irqRequest);
    rdc(1'b1, "status done", 16'h00c0);
    rdc(1'b0, "buffer a5", 16'h00a5);
    rdc(1'b1, "status after buffer read", 16'h0040);
    pulse(1'b1);
    flag("irq acked", 1'b0, irqRequest);
    endt("receive");

    bus(1'b1, 1'b0, 16'h0000);
    snd(8'h11, 8, 1'b0, 1'b0, 1'b0);
    snd(8'h3c, 8, 1'b0, 1'b0, 1'b0);
    flag("no irq when disabled", 1'b0, irqRequest);
    rdc(1'b0, "overrun", 16'hc03c);
    endt("overrun");

    snd(8'h5a, 8, 1'b0, 1'b0, 1'b1);
    rdc(1'b0, "framing", 16'ha05a);
    endt("framing");

    @(posedge core_clk) cfg.parityEn <= 1'b1;
    snd(8'h07, 8, 1'b1, 1'b1, 1'b0);
    rdc(1'b0, "parity bad", 16'h9007);
    snd(8'h07, 8, 1'b1, 1'b0, 1'b0);
    rdc(1'b0, "parity good", 16'h0007);
    @(posedge core_clk) cfg.parityOdd <= 1'b1;
    snd(8'h07, 8, 1'b1, 1'b1, 1'b0);
    rdc(1'b0, "odd parity good", 16'h0007);
    endt("parity");

    @(posedge core_clk) cfg <= '{4'h5, 1'b0, 1'b0, 1'b1};
    snd(8'h15, 5, 1'b0, 1'b0, 1'b0);
    rdc(1'b0, "five bit char", 16'h0015);
    endt("short format");

    @(posedge core_clk) cfg <= '{4'h8, 1'b0, 1'b0, 1'b0};
    snd(8'h5a, 8, 1'b0, 1'b0, 1'b1);
    rdc(1'b0, "errors hidden", 16'h005a);
    endt("error switch");

    @(posedge core_clk) cfg.errReport <= 1'b1;
    snd(8'h66, 8, 1'b0, 1'b0, 1'b0);
    rdc(1'b1, "done before tape", 16'h0080);
    bus(1'b1, 1'b0, 16'h0041);
    rdc(1'b1, "tape clears done", 16'h0040);
    flag("tape on", 1'b1, tapeAdvance);
    pulse(1'b0);
    rdc(1'b1, "status after init", 16'h0000);
    flag("tape after init", 1'b0, tapeAdvance);
    rdc(1'b0, "buffer kept", 16'h0066);
    bus(1'b0, 1'b0, 16'hffff);
    rdc(1'b0, "buffer write ignored", 16'h0066);
    endt("initialize");

    report_and_stop();
  end
endmodule
